// ==== design/adcsfc_cal_apply.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "adcsfc_map.svh"
module adcsfc_cal_apply #(
  parameter int SW = 2,
  parameter int W = 24
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_valid, // Sample strobe
  input wire logic [SW-1:0] i_setup, // Setup tag
  input wire logic [W-1:0] i_raw, // Offset-binary sample
  input wire logic [W-1:0] i_offset, // Zero-scale coefficient
  input wire logic [W-1:0] i_gain, // Full-scale coefficient
  output logic o_valid, // Result strobe
  output logic [SW-1:0] o_setup, // Setup tag
  output logic [W-1:0] o_data // Corrected sample
);
  localparam int PW = 2 * W + 2;
  logic valid_reg, valid_next;
  logic [SW-1:0] setup_reg, setup_next;
  logic [W-1:0] data_reg, data_next;
  logic signed [W:0] diff;
  logic signed [PW-1:0] prod, centred;

  always_comb begin
    diff = $signed({1'b0, i_raw}) - $signed({1'b0, i_offset});
    prod = diff * $signed({1'b0, i_gain});
    centred = (prod >>> `ADCSFC_GAIN_UNITY_SHIFT)
      + $signed({{(W+2){1'b0}}, `ADCSFC_MID_SCALE});
    valid_next = i_valid;
    setup_next = i_valid ? i_setup : setup_reg;
    data_next = data_reg;
    // Saturate rather than wrap so overrange stays monotonic
    if (i_valid) begin
      if (centred < 0)
        data_next = '0;
      else if (centred > $signed({{(W+2){1'b0}}, {W{1'b1}}}))
        data_next = '1;
      else
        data_next = centred[W-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_reg <= 1'b0;
      setup_reg <= '0;
      data_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      setup_reg <= setup_next;
      data_reg <= data_next;
    end
  end

  assign o_valid = valid_reg;
  assign o_setup = setup_reg;
  assign o_data = data_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  zero_center_a: assert property (
    i_valid && i_raw == i_offset |=> o_data == `ADCSFC_MID_SCALE)
    else $error("zero-scale input not mapped to mid scale");
  gain_sign_a: assert property (
    i_valid && i_raw > i_offset |=> o_data >= `ADCSFC_MID_SCALE)
    else $error("positive input corrected below mid scale");
  zero_gain_a: assert property (
    i_valid && i_gain == '0 |=> o_valid && o_data == `ADCSFC_MID_SCALE)
    else $error("zero gain did not collapse to mid scale");
endmodule
`default_nettype wire

// ==== design/adcsfc_map.svh ====
`ifndef ADCSFC_MAP_SVH
`define ADCSFC_MAP_SVH

// Register indices; byte address is four times the index
`define ADCSFC_IDX_FILTCFG3 6'h2B
`define ADCSFC_IDX_OFFSET_COEFF_SETUP0 6'h30
`define ADCSFC_IDX_OFFSET_COEFF_SETUP1 6'h31
`define ADCSFC_IDX_OFFSET_COEFF_SETUP2 6'h32
`define ADCSFC_IDX_OFFSET_COEFF_SETUP3 6'h33
`define ADCSFC_IDX_FULLSCALE_COEFF_SETUP0 6'h38
`define ADCSFC_IDX_FULLSCALE_COEFF_SETUP1 6'h39
`define ADCSFC_IDX_FULLSCALE_COEFF_SETUP2 6'h3A
`define ADCSFC_IDX_FULLSCALE_COEFF_SETUP3 6'h3B

// Reset values
`define ADCSFC_MID_SCALE 24'h800000
`define ADCSFC_OFFSET_RST `ADCSFC_MID_SCALE
`define ADCSFC_GAIN_RST 24'h500000
`define ADCSFC_FILTCFG3_RST 16'h0000

// Filter configuration layout
`define ADCSFC_FILTCFG3_RW_MASK 16'h8F7F
`define ADCSFC_SINC3MAP_BIT 15
`define ADCSFC_ENHEN_BIT 11
`define ADCSFC_ENHSEL_LSB 8
`define ADCSFC_ORDER_LSB 5
`define ADCSFC_ODR_LSB 0
`define ADCSFC_ODR_SLOWEST 5'h14

// Gain of 2^22 is unity in the correction path
`define ADCSFC_GAIN_UNITY_SHIFT 22

`endif

// ==== design/adcsfc_pkg.sv ====
package adcsfc_pkg;
  typedef logic [23:0] adcsfc_coeff_t;
  typedef logic [5:0] adcsfc_idx_t;
  typedef enum logic [1:0] {
    ADCSFC_ORD_SINC5_1 = 2'b00,
    ADCSFC_ORD_RSV1 = 2'b01,
    ADCSFC_ORD_RSV2 = 2'b10,
    ADCSFC_ORD_SINC3 = 2'b11
  } adcsfc_order_t;
endpackage

// ==== design/adcsfc_regs.sv ====
// Overview of operation
// - Filter order 00 selects sinc5 plus sinc1 (default); 11 selects sinc3.
// - Five-bit rate code sets conversion rate, 00000 fastest, slowest 10100.
// - Four 24-bit offset registers at 0x30-0x33, reset 0x800000.
// - Offset coefficient cancels zero-scale error of each setup.
// - Four 24-bit gain registers at 0x38-0x3B, reset 0x5XXXX0.
// - Gain coefficient cancels full-scale error of each setup.
// - Enhanced mains rejection works only with order code 00.
// - Setup 3 filter config is 16 bits at 0x2B, reset 0x0000.
`timescale 1ns/10ps
`default_nettype none
`include "adcsfc_map.svh"
module adcsfc_regs #(
  parameter int NSETUP = 4,
  parameter int W = 24,
  parameter logic [23:0] GAIN_RESET = `ADCSFC_GAIN_RST
) (
  input wire logic i_clk, // 250 MHz core clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB access phase
  input wire logic i_pwrite, // APB direction
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  input wire logic [3:0] i_pstrb, // APB byte strobes
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error, unmapped
  input wire logic i_conv_valid, // Raw sample strobe
  input wire logic [1:0] i_conv_setup, // Setup of channel
  input wire logic [W-1:0] i_conv_raw, // Raw sample
  output logic o_cal_valid, // Corrected strobe
  output logic [1:0] o_cal_setup, // Setup tag
  output logic [W-1:0] o_cal_data, // Corrected sample
  output var adcsfc_pkg::adcsfc_order_t o_filter_order_s3, // Order field
  output logic o_sinc3_sel_s3, // Sinc3 chosen
  output logic [4:0] o_data_rate_code_s3, // Rate code
  output logic o_mains_reject_active_s3, // Post filter on
  output logic [2:0] o_mains_reject_sel_s3, // Post filter type
  output logic o_sinc3_map_s3 // Direct decimation
);
  import adcsfc_pkg::*;

  localparam adcsfc_idx_t OFF_IDX [NSETUP] = '{`ADCSFC_IDX_OFFSET_COEFF_SETUP0,
    `ADCSFC_IDX_OFFSET_COEFF_SETUP1, `ADCSFC_IDX_OFFSET_COEFF_SETUP2, `ADCSFC_IDX_OFFSET_COEFF_SETUP3};
  localparam adcsfc_idx_t GAIN_IDX [NSETUP] = '{`ADCSFC_IDX_FULLSCALE_COEFF_SETUP0,
    `ADCSFC_IDX_FULLSCALE_COEFF_SETUP1, `ADCSFC_IDX_FULLSCALE_COEFF_SETUP2, `ADCSFC_IDX_FULLSCALE_COEFF_SETUP3};

  adcsfc_coeff_t offset_reg [NSETUP];
  adcsfc_coeff_t offset_next [NSETUP];
  adcsfc_coeff_t gain_reg [NSETUP];
  adcsfc_coeff_t gain_next [NSETUP];
  logic [15:0] filtcfg_reg, filtcfg_next;
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;
  logic [31:0] rd_data;
  logic rd_hit;
  adcsfc_idx_t idx;
  logic setup_ph, wr_acc;
  adcsfc_order_t order_s3;

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b])
        res[8*b +: 8] = wd[8*b +: 8];
    end
    return res;
  endfunction

  assign idx = i_paddr[7:2];
  assign setup_ph = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & i_pwrite;

  // Read decode; reserved bits and unused upper bytes read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b0;
    if (idx == `ADCSFC_IDX_FILTCFG3) begin
      rd_data = {16'h0000, filtcfg_reg};
      rd_hit = 1'b1;
    end
    for (int i = 0; i < NSETUP; i++) begin
      if (idx == OFF_IDX[i]) begin
        rd_data = {8'h00, offset_reg[i]};
        rd_hit = 1'b1;
      end
      if (idx == GAIN_IDX[i]) begin
        rd_data = {8'h00, gain_reg[i]};
        rd_hit = 1'b1;
      end
    end
  end

  // Register writes take effect only at the access-phase edge
  always_comb begin
    logic [31:0] merged;
    logic [15:0] fc;
    merged = 32'h0000_0000;
    fc = 16'h0000;
    offset_next = offset_reg;
    gain_next = gain_reg;
    filtcfg_next = filtcfg_reg;
    if (wr_acc) begin
      for (int i = 0; i < NSETUP; i++) begin
        if (idx == OFF_IDX[i]) begin
          merged = strb_merge({8'h00, offset_reg[i]}, i_pwdata, i_pstrb);
          offset_next[i] = merged[23:0];
        end
        if (idx == GAIN_IDX[i]) begin
          merged = strb_merge({8'h00, gain_reg[i]}, i_pwdata, i_pstrb);
          gain_next[i] = merged[23:0];
        end
      end
      if (idx == `ADCSFC_IDX_FILTCFG3) begin
        merged = strb_merge({16'h0000, filtcfg_reg}, i_pwdata, i_pstrb);
        fc = merged[15:0] & `ADCSFC_FILTCFG3_RW_MASK;
        // Undefined rate codes clamp to the slowest defined rate
        if (fc[`ADCSFC_ODR_LSB +: 5] > `ADCSFC_ODR_SLOWEST)
          fc[`ADCSFC_ODR_LSB +: 5] = `ADCSFC_ODR_SLOWEST;
        filtcfg_next = fc;
      end
    end
  end

  // Read data is captured in setup so the access phase needs no wait
  always_comb begin
    prdata_next = setup_ph ? rd_data : prdata_reg;
    err_next = setup_ph ? ~rd_hit : err_reg;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NSETUP; i++) begin
        offset_reg[i] <= `ADCSFC_OFFSET_RST;
        gain_reg[i] <= GAIN_RESET;
      end
      filtcfg_reg <= `ADCSFC_FILTCFG3_RST;
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      offset_reg <= offset_next;
      gain_reg <= gain_next;
      filtcfg_reg <= filtcfg_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & err_reg;

  assign order_s3 = adcsfc_order_t'(filtcfg_reg[`ADCSFC_ORDER_LSB +: 2]);
  assign o_filter_order_s3 = order_s3;
  assign o_sinc3_sel_s3 = (order_s3 == ADCSFC_ORD_SINC3);
  assign o_data_rate_code_s3 = filtcfg_reg[`ADCSFC_ODR_LSB +: 5];
  // Post filters sit behind sinc5+sinc1 only; other orders mask them
  assign o_mains_reject_active_s3 = filtcfg_reg[`ADCSFC_ENHEN_BIT]
    & (order_s3 == ADCSFC_ORD_SINC5_1);
  assign o_mains_reject_sel_s3 = filtcfg_reg[`ADCSFC_ENHSEL_LSB +: 3];
  assign o_sinc3_map_s3 = filtcfg_reg[`ADCSFC_SINC3MAP_BIT];

  logic sel_valid;
  logic [1:0] sel_setup;
  logic [W-1:0] sel_raw, sel_off, sel_gain;

  adcsfc_setup_sel #(
    .NSETUP(NSETUP),
    .SW(2),
    .W(W)
  ) u_sel (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_conv_valid),
    .i_setup(i_conv_setup),
    .i_raw(i_conv_raw),
    .i_offset(offset_reg),
    .i_gain(gain_reg),
    .o_valid(sel_valid),
    .o_setup(sel_setup),
    .o_raw(sel_raw),
    .o_offset(sel_off),
    .o_gain(sel_gain)
  );

  adcsfc_cal_apply #(
    .SW(2),
    .W(W)
  ) u_cal (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(sel_valid),
    .i_setup(sel_setup),
    .i_raw(sel_raw),
    .i_offset(sel_off),
    .i_gain(sel_gain),
    .o_valid(o_cal_valid),
    .o_setup(o_cal_setup),
    .o_data(o_cal_data)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence filt_wr;
    wr_acc && idx == `ADCSFC_IDX_FILTCFG3 && i_pstrb[0];
  endsequence
  sequence filt_rd;
    setup_ph && !i_pwrite && idx == `ADCSFC_IDX_FILTCFG3
      ##1 i_psel && i_penable;
  endsequence
  sequence bad_rd;
    setup_ph && !rd_hit ##1 i_psel && i_penable;
  endsequence
  // One offset and one gain read stand for the whole decode loop
  sequence off0_rd;
    setup_ph && !i_pwrite && idx == `ADCSFC_IDX_OFFSET_COEFF_SETUP0
      ##1 i_psel && i_penable;
  endsequence
  sequence fullscale_coeff_setup3_rd;
    setup_ph && !i_pwrite && idx == `ADCSFC_IDX_FULLSCALE_COEFF_SETUP3
      ##1 i_psel && i_penable;
  endsequence

  order_sinc3_a: assert property (
    filt_wr and i_pwdata[6:5] == 2'b11 |=>
      o_sinc3_sel_s3 && o_filter_order_s3 == ADCSFC_ORD_SINC3)
    else $error("order code 11 did not select sinc3");
  order_dflt_a: assert property (
    filt_wr and i_pwdata[6:5] == 2'b00 |=>
      !o_sinc3_sel_s3 && o_filter_order_s3 == ADCSFC_ORD_SINC5_1)
    else $error("order code 00 did not select sinc5 plus sinc1");
  rate_write_a: assert property (
    filt_wr and i_pwdata[4:0] <= `ADCSFC_ODR_SLOWEST |=>
      o_data_rate_code_s3 == $past(i_pwdata[4:0]))
    else $error("rate code not stored");
  rate_range_a: assert property (
    o_data_rate_code_s3 <= `ADCSFC_ODR_SLOWEST)
    else $error("rate code beyond slowest rate");
  offset_store_a: assert property (
    wr_acc && idx == `ADCSFC_IDX_OFFSET_COEFF_SETUP3 && i_pstrb == 4'hF |=>
      offset_reg[3] == $past(i_pwdata[23:0]))
    else $error("offset coefficient not stored");
  gain_store_a: assert property (
    wr_acc && idx == `ADCSFC_IDX_FULLSCALE_COEFF_SETUP0 && i_pstrb == 4'hF |=>
      gain_reg[0] == $past(i_pwdata[23:0]))
    else $error("gain coefficient not stored");
  mains_gate_a: assert property (
    o_mains_reject_active_s3 |->
      o_filter_order_s3 == ADCSFC_ORD_SINC5_1)
    else $error("post filter active without sinc5 plus sinc1");
  filt_read_a: assert property (
    filt_rd |-> o_prdata[31:16] == 16'h0000 && !o_pslverr
      && o_prdata[15:0] == filtcfg_reg)
    else $error("filter config read wrong");
  unmapped_a: assert property (
    bad_rd |-> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  conv_setup_a: assert property (
    i_conv_valid |-> ##2 o_cal_valid
      && o_cal_setup == $past(i_conv_setup, 2))
    else $error("conversion lost or setup tag wrong");
  offset_read_a: assert property (
    off0_rd |-> o_prdata == {8'h00, offset_reg[0]} && !o_pslverr)
    else $error("offset coefficient read wrong");
  gain_read_a: assert property (
    fullscale_coeff_setup3_rd |-> o_prdata == {8'h00, gain_reg[3]} && !o_pslverr)
    else $error("gain coefficient read wrong");
  lane_keep_a: assert property (
    wr_acc && idx == `ADCSFC_IDX_OFFSET_COEFF_SETUP0 && !i_pstrb[2] |=>
      offset_reg[0][23:16] == $past(offset_reg[0][23:16]))
    else $error("unstrobed offset byte changed");
  filt_hold_a: assert property (
    !(wr_acc && idx == `ADCSFC_IDX_FILTCFG3) |=> $stable(filtcfg_reg))
    else $error("filter config changed without a write");
  filt_rsvd_a: assert property (
    (filtcfg_reg & ~`ADCSFC_FILTCFG3_RW_MASK) == 16'h0000)
    else $error("reserved filter config bit set");
  enh_field_a: assert property (
    wr_acc && idx == `ADCSFC_IDX_FILTCFG3 && i_pstrb[1] |=>
      o_mains_reject_sel_s3 == $past(i_pwdata[10:8])
      && o_sinc3_map_s3 == $past(i_pwdata[15]))
    else $error("post filter fields not stored");
  // Unmapped writes must leave every kind of register alone
  unmapped_wr_a: assert property (
    wr_acc && !rd_hit |=> $stable(filtcfg_reg)
      && $stable(offset_reg[3]) && $stable(gain_reg[0]))
    else $error("unmapped write changed a register");
  conv_coeff_a: assert property (
    i_conv_valid |=> sel_off == $past(offset_reg[i_conv_setup])
      && sel_gain == $past(gain_reg[i_conv_setup]))
    else $error("conversion used another setup coefficients");
endmodule
`default_nettype wire

// ==== design/adcsfc_setup_sel.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcsfc_setup_sel #(
  parameter int NSETUP = 4,
  parameter int SW = 2,
  parameter int W = 24
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_valid, // Raw sample strobe
  input wire logic [SW-1:0] i_setup, // Setup of the channel
  input wire logic [W-1:0] i_raw, // Raw sample
  input wire logic [W-1:0] i_offset [NSETUP], // All offsets
  input wire logic [W-1:0] i_gain [NSETUP], // All gains
  output logic o_valid, // Selected strobe
  output logic [SW-1:0] o_setup, // Setup tag
  output logic [W-1:0] o_raw, // Sample
  output logic [W-1:0] o_offset, // Chosen offset
  output logic [W-1:0] o_gain // Chosen gain
);
  logic valid_reg, valid_next;
  logic [SW-1:0] setup_reg, setup_next;
  logic [W-1:0] raw_reg, raw_next, off_reg, off_next, gain_reg, gain_next;

  always_comb begin
    valid_next = i_valid;
    setup_next = setup_reg;
    raw_next = raw_reg;
    off_next = off_reg;
    gain_next = gain_reg;
    if (i_valid) begin
      setup_next = i_setup;
      raw_next = i_raw;
      off_next = i_offset[i_setup];
      gain_next = i_gain[i_setup];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_reg <= 1'b0;
      setup_reg <= '0;
      raw_reg <= '0;
      off_reg <= '0;
      gain_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      setup_reg <= setup_next;
      raw_reg <= raw_next;
      off_reg <= off_next;
      gain_reg <= gain_next;
    end
  end

  assign o_valid = valid_reg;
  assign o_setup = setup_reg;
  assign o_raw = raw_reg;
  assign o_offset = off_reg;
  assign o_gain = gain_reg;
endmodule
`default_nettype wire

// ==== verif/adcsfc_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcsfc_regs_tb;
  import adcsfc_pkg::*;
  // Arbitrary trimmed gain of the documented 0x5XXXX0 form
  localparam logic [23:0] GAIN_RST = 24'h5A5C30;
  localparam logic [1:0] SV [6] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2};
  localparam logic [23:0] DL [6] = '{24'h001234, 24'hFFF000, 24'h7FFFFF,
    24'hFFF000, 24'h000000, 24'h7EFBF9};
  logic i_clk, i_rst, psel, penable, pwrite, conv_valid, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb;
  logic [1:0] conv_setup;
  logic [23:0] conv_raw;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_cal_valid, sinc3, mains_on, map;
  logic [1:0] o_cal_setup;
  logic [23:0] o_cal_data;
  adcsfc_order_t ord;
  logic [4:0] rate;
  logic [2:0] mains_sel;
  int miscompares, checks, cyc;
  logic [23:0] off_v [4];
  logic [23:0] gn_v [4] = '{24'h400000, 24'h200000, 24'h600000, 24'h400000};
  logic [23:0] exp_q [$];
  logic [1:0] exp_s [$];
  longint exp_t [$];

  adcsfc_regs #(.GAIN_RESET(GAIN_RST)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_conv_valid(conv_valid), .i_conv_setup(conv_setup),
    .i_conv_raw(conv_raw), .o_cal_valid(o_cal_valid),
    .o_cal_setup(o_cal_setup), .o_cal_data(o_cal_data),
    .o_filter_order_s3(ord), .o_sinc3_sel_s3(sinc3),
    .o_data_rate_code_s3(rate), .o_mains_reject_active_s3(mains_on),
    .o_mains_reject_sel_s3(mains_sel), .o_sinc3_map_s3(map));

  always #2 i_clk = ~i_clk;

  function automatic logic [7:0] ba(input int idx);
    return 8'(idx * 4);
  endfunction

  // Offset-binary correction, saturated to the 24-bit code range
  function automatic logic [23:0] cal(input logic [23:0] raw, off, g);
    logic signed [53:0] y;
    y = ($signed({30'h0, raw}) - $signed({30'h0, off})) * $signed({30'h0, g});
    y = (y >>> 22) + 54'sh800000;
    if (y < 0) return 24'h000000;
    if (y > 54'shFFFFFF) return 24'hFFFFFF;
    return y[23:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Called just after a rising edge; waits on pready, never on a count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  // One raw sample per call; result is due two edges after it is taken
  task automatic conv_in(input logic [1:0] s, input logic [23:0] r);
    conv_valid <= 1'b1;
    conv_setup <= s;
    conv_raw <= r;
    exp_q.push_back(cal(r, off_v[s], gn_v[s]));
    exp_s.push_back(s);
    exp_t.push_back($time);
    @(posedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc >= 3000) begin
      miscompares++;
      finish_test;
    end
  end

  always @(posedge i_clk) begin
    if (o_cal_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else begin
        chk(32'(o_cal_data), 32'(exp_q.pop_front()));
        chk(32'(o_cal_setup), 32'(exp_s.pop_front()));
        chk(32'($time - exp_t.pop_front()), 32'hC);
      end
    end
  end

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    {psel, penable, pwrite, conv_valid} = 4'h0;
    {paddr, pwdata, pstrb, conv_setup, conv_raw} = '0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    for (int k = 0; k < 4; k++) begin
      rdchk(ba(8'h30 + k), 32'h00800000);
      rdchk(ba(8'h38 + k), {8'h00, GAIN_RST});
    end
    rdchk(ba(8'h2B), 32'h00000000);
    chk(32'(ord), 32'h0);
    chk(32'(rate), 32'h0);
    chk(32'(o_pready), 32'h1);
    $display("test reset_values done");
    // Top byte is outside the 24-bit coefficient and must read back 0
    for (int k = 0; k < 4; k++) begin
      off_v[k] = 24'h7F0000 + 24'(k) * 24'h010203;
      apb(1'b1, ba(8'h30 + k), {8'hFF, off_v[k]}, 4'hF);
      apb(1'b1, ba(8'h38 + k), {8'hFF, gn_v[k]}, 4'hF);
    end
    for (int k = 0; k < 4; k++) begin
      rdchk(ba(8'h30 + k), {8'h00, off_v[k]});
      rdchk(ba(8'h38 + k), {8'h00, gn_v[k]});
    end
    apb(1'b1, ba(8'h30), 32'hFFFFAAFF, 4'h2);
    off_v[0][15:8] = 8'hAA;
    rdchk(ba(8'h30), {8'h00, off_v[0]});
    $display("test coefficients done");
    // Sinc3 with one shared rate, as every enabled setup must use
    apb(1'b1, ba(8'h2B), 32'h0000FFFF, 4'hF);
    rdchk(ba(8'h2B), 32'h00008F74);
    chk(32'(ord), 32'h3);
    chk(32'(sinc3), 32'h1);
    chk(32'(mains_on), 32'h0);
    chk(32'(mains_sel), 32'h7);
    chk(32'(map), 32'h1);
    chk(32'(rate), 32'h14);
    apb(1'b1, ba(8'h2B), 32'h00000800, 4'hF);
    chk(32'(ord), 32'h0);
    chk(32'(sinc3), 32'h0);
    chk(32'(mains_on), 32'h1);
    // Undefined order code is stored but gates the post filter off
    apb(1'b1, ba(8'h2B), 32'h00000820, 4'hF);
    chk(32'(ord), 32'h1);
    chk(32'(sinc3), 32'h0);
    chk(32'(mains_on), 32'h0);
    for (int c = 0; c <= 20; c++) begin
      apb(1'b1, ba(8'h2B), 32'(c), 4'hF);
      chk(32'(rate), 32'(c));
      rdchk(ba(8'h2B), 32'(c));
    end
    $display("test filter_config done");
    rdchk(ba(8'h00), 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, ba(8'h2C), 32'hFFFFFFFF, 4'hF);
    chk(32'(err), 32'h1);
    rdchk(ba(8'h3B), {8'h00, gn_v[3]});
    chk(32'(err), 32'h0);
    $display("test unmapped done");
    // Back-to-back samples across setups, both saturation ends
    for (int i = 0; i < 6; i++)
      conv_in(SV[i], off_v[SV[i]] + DL[i]);
    conv_valid <= 1'b0;
    repeat (5) @(posedge i_clk);
    // Zero gain must collapse any input to mid scale
    apb(1'b1, ba(8'h39), 32'h00000000, 4'hF);
    gn_v[1] = 24'h000000;
    conv_in(2'h1, 24'h123456);
    conv_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(32'(exp_q.size()), 32'h0);
    $display("test conversion done");
    // Mid-run reset must restore every written register
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdchk(ba(8'h33), 32'h00800000);
    rdchk(ba(8'h39), {8'h00, GAIN_RST});
    rdchk(ba(8'h2B), 32'h00000000);
    chk(32'(ord), 32'h0);
    $display("test mid_reset done");
    finish_test;
  end
endmodule
`default_nettype wire
